/* File: hdl/dmd_defines.svh */
// constants of the dual multiplier datapath
`ifndef DMD_DEFINES_SVH
`define DMD_DEFINES_SVH
`define DMD_ADDR_CTRL     12'h000
`define DMD_ADDR_STAT     12'h004
`define DMD_ADDR_MASK     12'h008
`define DMD_ADDR_OPA      12'h00c
`define DMD_ADDR_OPB      12'h010
`define DMD_ADDR_COEF     12'h014
`define DMD_ADDR_CMD      12'h018
`define DMD_ADDR_ACC1_LO  12'h01c
`define DMD_ADDR_ACC1_HI  12'h020
`define DMD_ADDR_ACC2_LO  12'h024
`define DMD_ADDR_ACC2_HI  12'h028
`define DMD_ADDR_PC       12'h02c
`define DMD_ADDR_CADDR    12'h030
`define DMD_ADDR_CINFO    12'h034
// ctrl bit positions
`define DMD_C_FRACTIONAL_MODE_BIT        0
`define DMD_C_M40         1
`define DMD_C_RDM         2
`define DMD_C_D_UNIT_SATURATION_MODE        3
`define DMD_C_MULTIPLY_SATURATION_MODE        4
`define DMD_C_SIGN_EXTENSION_MODE_BIT        5
// command fields
`define DMD_K_OP_LO       0
`define DMD_K_OP_HI       2
`define DMD_K_UNS_A       3
`define DMD_K_UNS_B       4
`define DMD_K_UNS_C       5
`define DMD_K_RND         6
`define DMD_K_W40         7
`define DMD_K_MAR1        8
`define DMD_K_MAR2        9
`define DMD_K_CEXT        10
`define DMD_K_RPT_LO      16
`define DMD_K_RPT_HI      31
// status bits
`define DMD_S_OV1         0
`define DMD_S_OV2         1
`define DMD_S_DONE        2
`define DMD_S_BERR        3
`define DMD_S_W           4
// opcodes
`define DMD_OP_NOP1       3'h1
`define DMD_OP_NOP2       3'h2
`define DMD_OP_SHARED     3'h3
`define DMD_OP_SPLIT      3'h4
// arithmetic constants
`define DMD_RND_HALF      40'h0000008000
`define DMD_RND_MASK      40'hffffff0000
`define DMD_MAX40         40'h7fffffffff
`define DMD_MIN40         40'h8000000000
`define DMD_MAX32         40'h007fffffff
`define DMD_MIN32         40'hff80000000
`define DMD_PROD_MAX      32'h7fffffff
`define DMD_SQ_NEG        17'h18000
`define DMD_ONE16         16'h0001
`define DMD_TWO16         16'h0002
`endif

/* File: hdl/dmd_pkg.sv */
// types of the dual multiplier datapath
package dmd_pkg;
  typedef struct packed {
    logic fractional_mode_bit;
    logic wide_accumulator_mode;
    logic rounding_mode_bit;
    logic d_unit_saturation_mode;
    logic multiply_saturation_mode;
    logic sign_extension_mode_bit;
  } dmd_mode_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        irq;
    logic [39:0] acc1;
    logic [39:0] acc2;
    logic        ov1;
    logic        ov2;
    logic [15:0] pc;
  } dmd_out_t;

  typedef struct packed {
    dmd_mode_t   mode;
    logic [4:0]  status;
    logic [4:0]  mask;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [31:0] coef;
    logic [15:0] caddr;
    logic        c_ext;
    logic        ph_valid;
    logic        ph_write;
    logic [11:0] ph_addr;
    logic [31:0] cmd;
    logic [15:0] rpt;
    logic        busy;
    dmd_out_t    o;
  } dmd_state_t;
endpackage

/* File: hdl/dmd_top.sv */
// dual multiplier datapath with an ahb-lite register slave
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
// Functional notes
// - nop advances pc by one or two
// - both products finish in one cycle
// - unsigned operand is zero extended to 17
// - otherwise sign extended per extension mode, split coefficient halves always
// - fractional mode shifts product left one
// - product overflow governed by multiply saturation
// - 32-bit product sign extended to 40
// - round only with qualifier, method by mode
// - overflow per wide mode sets flag
// - overflow saturates per d-unit saturation mode
// - 40-bit qualifier forces wide mode locally
// - shared coefficient feeds both multipliers
// - coefficient in external memory gives bus error
// - address modify disables matching multiplier
// - split form shares one data operand
// - low half at address plus or minus one
// - high half second bus, low first bus
// - nop and multiplies repeat as loop body
`timescale 1ns/1ns
`include "dmd_defines.svh"
module dmd_top
  import dmd_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq,
  output logic      [39:0] first_destination_accumulator,
  output logic      [39:0] second_destination_accumulator,
  output logic             first_accum_overflow_flag,
  output logic             second_accum_overflow_flag,
  output logic      [15:0] program_counter
);

  //------------------------------------------------------------
  // arithmetic helpers
  //------------------------------------------------------------
  // operand extension to 17 bits
  function automatic logic [16:0] dmd_ext(input logic [15:0] v, input logic uns, input logic sx);
    logic s;
    s = ~uns & sx & v[15];
    return {s, v};
  endfunction

  // one multiplier lane: product, shift, extend, round, overflow, saturate
  function automatic logic [40:0] dmd_lane(input logic [16:0] a, input logic [16:0] b,
                                           input dmd_mode_t m, input logic rnd, input logic w40);
    logic [33:0] p;
    logic [31:0] p32;
    logic [39:0] r;
    logic [39:0] mx;
    logic [39:0] mn;
    logic        ovf;
    p   = 34'($signed(a) * $signed(b));
    p32 = m.fractional_mode_bit ? {p[30:0], 1'b0} : p[31:0];
    if (m.multiply_saturation_mode && m.fractional_mode_bit
        && a == `DMD_SQ_NEG && b == `DMD_SQ_NEG)
      p32 = `DMD_PROD_MAX;
    r = {{8{p32[31]}}, p32};
    if (rnd)
    begin
      if (m.rounding_mode_bit && r[15:0] == 16'h8000)
        r = r + (r[16] ? `DMD_RND_HALF : 40'h0);
      else
        r = r + `DMD_RND_HALF;
      r = r & `DMD_RND_MASK;
    end
    mx  = w40 ? `DMD_MAX40 : `DMD_MAX32;
    mn  = w40 ? `DMD_MIN40 : `DMD_MIN32;
    ovf = w40 ? 1'b0 : (r[39:31] != {9{r[31]}});
    if (ovf && m.d_unit_saturation_mode)
      r = r[39] ? mn : mx;
    return {ovf, r};
  endfunction

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  dmd_state_t s_q;
  dmd_state_t s_d;

  logic [16:0] xa;
  logic [16:0] xb;
  logic [16:0] ch;
  logic [16:0] cl;
  logic [40:0] r1;
  logic [40:0] r2;
  logic        rnd_c;
  logic        w40_c;
  logic [2:0]  op_c;
  logic        wr_ph;
  logic [4:0]  ev;

  always_comb
  begin
    s_d   = s_q;
    ev    = 5'h00;
    op_c  = s_q.cmd[`DMD_K_OP_HI:`DMD_K_OP_LO];
    rnd_c = s_q.cmd[`DMD_K_RND];
    w40_c = s_q.mode.wide_accumulator_mode | s_q.cmd[`DMD_K_W40];
    xa    = dmd_ext(s_q.opa, s_q.cmd[`DMD_K_UNS_A], s_q.mode.sign_extension_mode_bit);
    xb    = dmd_ext(s_q.opb, s_q.cmd[`DMD_K_UNS_B], s_q.mode.sign_extension_mode_bit);
    if (op_c == `DMD_OP_SPLIT)
    begin
      // high half from second bus, low half from first bus
      ch = dmd_ext(s_q.coef[31:16], s_q.cmd[`DMD_K_UNS_C], 1'b1);
      cl = dmd_ext(s_q.coef[15:0], s_q.cmd[`DMD_K_UNS_C], 1'b1);
      xb = xa;
    end
    else
    begin
      ch = dmd_ext(s_q.coef[15:0], s_q.cmd[`DMD_K_UNS_C], s_q.mode.sign_extension_mode_bit);
      cl = ch;
    end
    // lane 1 from xa and cl, lane 2 from xb and ch, all from registered operands
    r1 = dmd_lane(xa, cl, s_q.mode, rnd_c, w40_c);
    r2 = dmd_lane(xb, ch, s_q.mode, rnd_c, w40_c);

    //------------------------------------------------------------
    // execution
    //------------------------------------------------------------
    if (s_q.busy)
    begin
      case (op_c)
        `DMD_OP_NOP1: s_d.o.pc = s_q.o.pc + `DMD_ONE16;
        `DMD_OP_NOP2: s_d.o.pc = s_q.o.pc + `DMD_TWO16;
        `DMD_OP_SHARED, `DMD_OP_SPLIT:
        begin
          if (s_q.c_ext)
            ev[`DMD_S_BERR] = 1'b1;
          else
          begin
            if (!s_q.cmd[`DMD_K_MAR1])
            begin
              s_d.o.acc1 = r1[39:0];
              s_d.o.ov1  = s_q.o.ov1 | r1[40];
              ev[`DMD_S_OV1] = r1[40];
            end
            if (!s_q.cmd[`DMD_K_MAR2])
            begin
              s_d.o.acc2 = r2[39:0];
              s_d.o.ov2  = s_q.o.ov2 | r2[40];
              ev[`DMD_S_OV2] = r2[40];
            end
          end
        end
        default: ;
      endcase
      // single-instruction repeat loop
      if (s_q.rpt == 16'h0000)
      begin
        s_d.busy = 1'b0;
        ev[`DMD_S_DONE] = 1'b1;
      end
      else
        s_d.rpt = s_q.rpt - 16'h0001;
    end

    //------------------------------------------------------------
    // ahb-lite slave, zero wait states
    //------------------------------------------------------------
    s_d.o.hreadyout = 1'b1;
    wr_ph = s_q.ph_valid & s_q.ph_write;
    if (wr_ph)
    begin
      case (s_q.ph_addr)
        `DMD_ADDR_CTRL:
        begin
          s_d.mode.fractional_mode_bit      = hwdata[`DMD_C_FRACTIONAL_MODE_BIT];
          s_d.mode.wide_accumulator_mode    = hwdata[`DMD_C_M40];
          s_d.mode.rounding_mode_bit        = hwdata[`DMD_C_RDM];
          s_d.mode.d_unit_saturation_mode   = hwdata[`DMD_C_D_UNIT_SATURATION_MODE];
          s_d.mode.multiply_saturation_mode = hwdata[`DMD_C_MULTIPLY_SATURATION_MODE];
          s_d.mode.sign_extension_mode_bit  = hwdata[`DMD_C_SIGN_EXTENSION_MODE_BIT];
        end
        `DMD_ADDR_MASK:  s_d.mask = hwdata[4:0];
        `DMD_ADDR_OPA:   s_d.opa  = hwdata[15:0];
        `DMD_ADDR_OPB:   s_d.opb  = hwdata[15:0];
        `DMD_ADDR_COEF:  s_d.coef = hwdata;
        `DMD_ADDR_CADDR: s_d.caddr = hwdata[15:0];
        `DMD_ADDR_CINFO: s_d.c_ext = hwdata[0];
        `DMD_ADDR_PC:    s_d.o.pc = hwdata[15:0];
        `DMD_ADDR_CMD:
        begin
          if (!s_q.busy)
          begin
            s_d.cmd  = hwdata;
            s_d.rpt  = hwdata[`DMD_K_RPT_HI:`DMD_K_RPT_LO];
            s_d.busy = 1'b1;
            s_d.o.ov1 = 1'b0;
            s_d.o.ov2 = 1'b0;
          end
        end
        default: ;
      endcase
    end
    s_d.ph_valid = hsel & hready & htrans[1];
    s_d.ph_write = hwrite;
    s_d.ph_addr  = haddr[11:0];
    s_d.o.hrdata = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      case (haddr[11:0])
        `DMD_ADDR_CTRL:    s_d.o.hrdata = {26'h0, s_q.mode.sign_extension_mode_bit,
                                           s_q.mode.multiply_saturation_mode, s_q.mode.d_unit_saturation_mode,
                                           s_q.mode.rounding_mode_bit, s_q.mode.wide_accumulator_mode,
                                           s_q.mode.fractional_mode_bit};
        `DMD_ADDR_STAT:    s_d.o.hrdata = {27'h0, s_q.busy, s_q.status[3:0]};
        `DMD_ADDR_MASK:    s_d.o.hrdata = {27'h0, s_q.mask};
        `DMD_ADDR_OPA:     s_d.o.hrdata = {16'h0, s_q.opa};
        `DMD_ADDR_OPB:     s_d.o.hrdata = {16'h0, s_q.opb};
        `DMD_ADDR_COEF:    s_d.o.hrdata = s_q.coef;
        `DMD_ADDR_CMD:     s_d.o.hrdata = s_q.cmd;
        `DMD_ADDR_ACC1_LO: s_d.o.hrdata = s_q.o.acc1[31:0];
        `DMD_ADDR_ACC1_HI: s_d.o.hrdata = {23'h0, s_q.o.ov1, s_q.o.acc1[39:32]};
        `DMD_ADDR_ACC2_LO: s_d.o.hrdata = s_q.o.acc2[31:0];
        `DMD_ADDR_ACC2_HI: s_d.o.hrdata = {23'h0, s_q.o.ov2, s_q.o.acc2[39:32]};
        `DMD_ADDR_PC:      s_d.o.hrdata = {16'h0, s_q.o.pc};
        // low half address: ea+1 when even, ea-1 when odd
        `DMD_ADDR_CADDR:   s_d.o.hrdata = {s_q.caddr[0] ? s_q.caddr - 16'h0001
                                                        : s_q.caddr + 16'h0001, s_q.caddr};
        `DMD_ADDR_CINFO:   s_d.o.hrdata = {31'h0, s_q.c_ext};
        default:           s_d.o.hrdata = 32'h0000_0000;
      endcase
    end

    //------------------------------------------------------------
    // sticky status, clear on read, set wins
    //------------------------------------------------------------
    if (hsel && hready && htrans[1] && !hwrite && haddr[11:0] == `DMD_ADDR_STAT)
      s_d.status = 5'h00;
    s_d.status = s_d.status | ev;
    s_d.o.irq  = |(s_d.status & s_q.mask);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign hrdata                         = s_q.o.hrdata;
  assign hreadyout                      = s_q.o.hreadyout;
  assign hresp                          = 1'b0;
  assign irq                            = s_q.o.irq;
  assign first_destination_accumulator  = s_q.o.acc1;
  assign second_destination_accumulator = s_q.o.acc2;
  assign first_accum_overflow_flag      = s_q.o.ov1;
  assign second_accum_overflow_flag     = s_q.o.ov2;
  assign program_counter                = s_q.o.pc;

endmodule

/* File: verification/dmd_properties.sv */
// port assertions of the dual multiplier datapath
`timescale 1ns/1ns
`include "dmd_defines.svh"
module dmd_properties
  import dmd_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [39:0] first_destination_accumulator,
  input wire logic [39:0] second_destination_accumulator,
  input wire logic        first_accum_overflow_flag,
  input wire logic        second_accum_overflow_flag,
  input wire logic [15:0] program_counter
);
  //----------------------------------------
  // mode tracking from bus writes
  //----------------------------------------
  logic [11:0] pa_q;
  logic        pw_q;
  logic [5:0]  md_q;
  logic [11:0] pa2_q;
  logic        pw2_q;
  logic        wq_q;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pa_q  <= 12'h000;
      pw_q  <= 1'b0;
      md_q  <= 6'h00;
      pa2_q <= 12'h000;
      pw2_q <= 1'b0;
      wq_q  <= 1'b0;
    end
    else
    begin
      pa_q  <= haddr[11:0];
      pw_q  <= hsel && hready && htrans[1] && hwrite;
      pa2_q <= pa_q;
      pw2_q <= pw_q;
      if (pw_q && pa_q == `DMD_ADDR_CTRL)
        md_q <= hwdata[5:0];
      // per-command wide qualifier
      if (pw_q && pa_q == `DMD_ADDR_CMD)
        wq_q <= hwdata[`DMD_K_W40];
    end
  //----------------------------------------
  // properties
  //----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_pc_step: assert property ($changed(program_counter) |-> (pw2_q && pa2_q == `DMD_ADDR_PC) ||
    (program_counter - $past(program_counter)) inside {16'h0001, 16'h0002}) else $error("pc bad step");
  chk_sat_first: assert property ($rose(first_accum_overflow_flag) && md_q[3] |->
    first_destination_accumulator inside {40'h007fffffff, 40'hff80000000}) else $error("acc1 not saturated");
  chk_sat_second: assert property ($rose(second_accum_overflow_flag) && md_q[3] |->
    second_destination_accumulator inside {40'h007fffffff, 40'hff80000000}) else $error("acc2 not saturated");
  chk_ov_narrow1: assert property ($rose(first_accum_overflow_flag) |-> !md_q[1] && !wq_q)
    else $error("ov1 in wide mode");
  chk_ov_narrow2: assert property ($rose(second_accum_overflow_flag) |-> !md_q[1] && !wq_q)
    else $error("ov2 in wide mode");
  chk_ov_keep1: assert property ($rose(first_accum_overflow_flag) && !md_q[3] |->
    !(first_destination_accumulator[39:31] inside {9'h000, 9'h1ff})) else $error("ov1 without overflow");
  chk_ext_first: assert property ($changed(first_destination_accumulator) && !first_accum_overflow_flag
    && !md_q[1] && !wq_q |-> first_destination_accumulator[39:31] inside {9'h000, 9'h1ff}) else $error("acc1 ext");
  chk_ext_second: assert property ($changed(second_destination_accumulator) && !second_accum_overflow_flag
    && !md_q[1] && !wq_q |-> second_destination_accumulator[39:31] inside {9'h000, 9'h1ff}) else $error("acc2 ext");
endmodule
bind dmd_top dmd_properties u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .first_destination_accumulator, .second_destination_accumulator, .first_accum_overflow_flag,
  .second_accum_overflow_flag, .program_counter);

/* File: verification/dmd_host_model.sv */
// bus master standing in for the decoder side
`timescale 1ns/1ns
module dmd_host_model
(
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule

/* File: verification/test_dual_multiplier_datapath.sv */
// self-checking bench of the dual multiplier datapath
`timescale 1ns/1ns
`include "dmd_defines.svh"
module test_dual_multiplier_datapath
  import dmd_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hrdy, hresp, irq, ov1, ov2, ua, ub, uc, sx;
  logic [31:0] haddr, hwdata, hrdata, r, lf, cf, cmd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [39:0] acc1, acc2, e1, e2;
  logic [40:0] l1, l2;
  logic [15:0] pc, ep, a;
  logic [5:0]  ctl;
  int          err_total, samples_checked, cyc, i;
  dmd_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
    .hresp(hresp), .irq(irq), .first_destination_accumulator(acc1), .second_destination_accumulator(acc2),
    .first_accum_overflow_flag(ov1), .second_accum_overflow_flag(ov2), .program_counter(pc));
  dmd_host_model u_host (.hclk(hclk), .hready(hrdy), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [40:0] lane(input logic [15:0] x, y, input logic sa, sb, input logic [5:0] m,
                                       input logic rn, w);
    longint p;
    logic [39:0] v;
    logic        o;
    p = (sa ? longint'($signed(x)) : longint'(x)) * (sb ? longint'($signed(y)) : longint'(y));
    if (m[0])
      p = p <<< 1;
    if (m[4] && m[0] && sa && sb && x == 16'h8000 && y == 16'h8000)
      p = 64'h000000007fffffff;
    v = {{8{p[31]}}, p[31:0]};
    if (rn)
      v = (m[2] && v[16:0] == 17'h08000) ? v & 40'hffffff0000 : (v + 40'h8000) & 40'hffffff0000;
    o = !(m[1] || w) && !(v[39:31] inside {9'h000, 9'h1ff});
    if (o && m[3])
      v = v[39] ? 40'hff80000000 : 40'h007fffffff;
    return {o, v};
  endfunction
  task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic run(input logic [31:0] c, c2, km, st);
    u_host.xfer(1'b1, `DMD_ADDR_CMD, c, r);
    if (c2 != 32'h0)
      u_host.xfer(1'b1, `DMD_ADDR_CMD, c2, r);
    for (int k = 0; k < 80 && irq !== 1'b1; k++)
      @(posedge hclk);
    chk("irq set", {39'h0, irq}, 40'h1);
    chk("hresp", {39'h0, hresp}, 40'h0);
    u_host.xfer(1'b0, `DMD_ADDR_STAT, 32'h0, r);
    chk("status", {8'h00, r & km}, {8'h00, st});
    repeat (2) @(posedge hclk);
    chk("irq clear", {39'h0, irq}, 40'h0);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_total++;
      give_verdict();
    end
  end
  initial
  begin
    hresetn = 1'b0;
    lf = 32'ha520d9d3;
    e1 = 40'h0;
    e2 = 40'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    u_host.xfer(1'b1, `DMD_ADDR_MASK, 32'h4, r);
    u_host.xfer(1'b0, 12'h040, 32'h0, r);
    chk("unmapped", {8'h00, r}, 40'h0);
    for (i = 0; i < 2; i++)
    begin
      a = i ? 16'h0777 : 16'h1234;
      u_host.xfer(1'b1, `DMD_ADDR_CADDR, {16'h0, a}, r);
      u_host.xfer(1'b0, `DMD_ADDR_CADDR, 32'h0, r);
      chk("coef addr", {8'h00, r}, {8'h00, a ^ 16'h0001, a});
    end
    for (i = 0; i < 18; i++)
    begin
      lf = nx(lf);
      ctl = i == 0 ? 6'h39 : i == 1 ? 6'h31 : i == 2 ? 6'h33 : lf[5:0];
      cf = i < 3 ? 32'h80008000 : nx(lf);
      lf = nx(nx(lf));
      cmd = i < 3 ? 32'h43 : {14'h0, lf[17:16], 6'h0, lf[9:3], i[0] ? `DMD_OP_SPLIT : `DMD_OP_SHARED};
      lf = nx(lf);
      {ua, ub, uc, sx} = {cmd[3], cmd[4], cmd[5], ctl[5]};
      u_host.xfer(1'b1, `DMD_ADDR_CTRL, {26'h0, ctl}, r);
      u_host.xfer(1'b1, `DMD_ADDR_OPA, i < 3 ? 32'h8000 : lf, r);
      u_host.xfer(1'b1, `DMD_ADDR_OPB, i < 3 ? 32'h8000 : nx(lf), r);
      u_host.xfer(1'b1, `DMD_ADDR_COEF, cf, r);
      if (cmd[2:0] == `DMD_OP_SHARED)
      begin
        l1 = lane(i < 3 ? 16'h8000 : lf[15:0], cf[15:0], !ua && sx, !uc && sx, ctl, cmd[6], cmd[7]);
        l2 = lane(i < 3 ? 16'h8000 : 16'(nx(lf)), cf[15:0], !ub && sx, !uc && sx, ctl, cmd[6], cmd[7]);
      end
      else
      begin
        l1 = lane(lf[15:0], cf[15:0], !ua && sx, !uc, ctl, cmd[6], cmd[7]);
        l2 = lane(lf[15:0], cf[31:16], !ua && sx, !uc, ctl, cmd[6], cmd[7]);
      end
      l1 = cmd[8] ? {1'b0, e1} : l1;
      l2 = cmd[9] ? {1'b0, e2} : l2;
      {e1, e2} = {l1[39:0], l2[39:0]};
      run(cmd, 32'h0, 32'h1f, {27'h0, 3'h1, l2[40], l1[40]});
      chk("acc1", acc1, e1);
      chk("acc2", acc2, e2);
      chk("ov1", {39'h0, ov1}, {39'h0, l1[40]});
      chk("ov2", {39'h0, ov2}, {39'h0, l2[40]});
      u_host.xfer(1'b0, `DMD_ADDR_CTRL, 32'h0, r);
      chk("ctrl", {8'h00, r}, {34'h0, ctl});
    end
    ep = 16'hfffe;
    u_host.xfer(1'b1, `DMD_ADDR_PC, {16'h0, ep}, r);
    for (i = 1; i < 3; i++)
    begin
      ep = ep + i * (i == 1 ? 1 : 4);
      run(i == 1 ? 32'h1 : 32'h30002, 32'h0, 32'h1f, 32'h4);
      chk("pc", {24'h0, pc}, {24'h0, ep});
    end
    u_host.xfer(1'b1, `DMD_ADDR_MASK, 32'hc, r);
    u_host.xfer(1'b1, `DMD_ADDR_CINFO, 32'h1, r);
    run(32'h20003, 32'h1, 32'h8, 32'h8);
    chk("berr acc1", acc1, e1);
    chk("busy pc", {24'h0, pc}, {24'h0, ep});
    u_host.xfer(1'b1, `DMD_ADDR_CINFO, 32'h0, r);
    u_host.xfer(1'b1, `DMD_ADDR_MASK, 32'h0, r);
    u_host.xfer(1'b1, `DMD_ADDR_CMD, 32'h1, r);
    repeat (6) @(posedge hclk);
    chk("irq masked", {39'h0, irq}, 40'h0);
    chk("masked pc", {24'h0, pc}, {24'h0, ep + 16'h0001});
    u_host.xfer(1'b1, `DMD_ADDR_MASK, 32'h4, r);
    run(32'h0, 32'h0, 32'h0, 32'h0);
    give_verdict();
  end
endmodule
